/* rtl/psq_pkg.sv */
// Purpose: types of the pushbutton power sequencer
// Assumes: constants come from psq_regs.svh
// Notes:   phase codes are Gray along the power-on and power-off path
`include "psq_regs.svh"

package psq_pkg;

    // sequencer phases
    typedef enum logic [3:0] {
        PSQ_IDLE    = 4'h0,
        PSQ_ON_DB   = 4'h1,
        PSQ_BLANK   = 4'h3,
        PSQ_REL_ON  = 4'h2,
        PSQ_RUN     = 4'h6,
        PSQ_OFF_DB  = 4'h7,
        PSQ_PDOWN   = 4'h5,
        PSQ_OFF_REL = 4'h4,
        PSQ_LOCKOUT = 4'hC
    } psq_phase_t;

    // complete state of the sequencer core
    typedef struct packed {
        psq_phase_t                 phase;
        logic [`PSQ_MS_W-1:0]       ms_cnt;
        logic [`PSQ_KILL_W-1:0]     kill_cnt;
        logic                       kill_low;
        logic                       pb_prev;
        logic                       en_on;
        logic                       irq_n;
        logic                       power_enable;
    } psq_core_t;

endpackage

/* rtl/psq_regs.svh */
// Purpose: named constants of the pushbutton power sequencer
// Assumes: 50 MHz block clock, 1 ms time base
// Notes:   definitions only; included by the package, the sequencer, the tick and the bench
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH

// clock and time base
`define PSQ_CLK_MHZ      50
`define PSQ_TICK_US      1000
`define PSQ_TICK_CYC     (`PSQ_TICK_US * `PSQ_CLK_MHZ)
`define PSQ_TICK_W       16

// kill glitch filter, figures in microseconds and cycles
`define PSQ_KILL_PW_US   30
`define PSQ_KILL_CYC     (`PSQ_KILL_PW_US * `PSQ_CLK_MHZ)
`define PSQ_KILL_LAT     3
`define PSQ_KILL_W       11
`define PSQ_KILL_THR     (`PSQ_KILL_CYC - `PSQ_KILL_LAT)

// millisecond timer width and phase lengths in ms
`define PSQ_MS_W         11
`define PSQ_EXT_W        8
`define PSQ_EXT_PAD      3
`define PSQ_DB_MS        11'h020
`define PSQ_BLANK_MS     11'h200
`define PSQ_PDOWN_MS     11'h400
`define PSQ_LOCK_MS      11'h100

// synchroniser reset values
`define PSQ_PINS_RST     2'h3
`define PSQ_EXT_RST      16'h0000

`endif

/* rtl/psq_sequencer.sv */
// Purpose: pushbutton power on/off sequencer with processor handshake
// Assumes: 50 MHz clk, synchronous active-low reset at power-up
// Notes:   phase timers count 1 ms ticks, the kill filter counts clk cycles; pins are synchronised first
// Operation
// - reset leaves enable off, converter held off
// - enable only after 32ms plus extension low
// - button high abandons a running on or off debounce
// - on debounce extended by on_time_extend
// - off debounce extended by off_time_extend
// - kill ignored for 512ms after enable
// - button ignored during the blanking window
// - kill low at blank end aborts power
// - button release debounced 32ms before new press
// - validated off press drives interrupt low
// - no kill within 1024ms releases enable
// - kill in power-down window releases immediately
// - kill after blanking releases enable immediately
// - 256ms button lockout after kill release
// - enable polarity selectable, behaviour otherwise same
// - kill pulses under 30us are ignored
// - after power-off return idle, await press
// - enable released within 30us of kill after blanking
`timescale 1ns/1ps
`include "psq_regs.svh"

module psq_sequencer
    import psq_pkg::*;
#(
    parameter int   TICK_CYCLES   = `PSQ_TICK_CYC,
    parameter logic EN_ACTIVE_LOW = 1'b0
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // pushbutton and processor pins
    input  wire logic                  push_button_n,
    input  wire logic                  kill_request_n,
    // debounce extensions in ms
    input  wire logic [`PSQ_EXT_W-1:0] on_time_extend,
    input  wire logic [`PSQ_EXT_W-1:0] off_time_extend,
    // power and interrupt outputs
    output logic                       power_enable,
    output logic                       shutdown_irq_n
);

    localparam logic [`PSQ_KILL_W-1:0] KILL_LAST = `PSQ_KILL_W'(`PSQ_KILL_THR - 1);

    psq_core_t               st;
    psq_core_t               next_st;
    logic                    pb_s;
    logic                    kill_s;
    logic [`PSQ_EXT_W-1:0]   on_ext;
    logic [`PSQ_EXT_W-1:0]   off_ext;
    logic                    tick;
    logic                    tmr_restart;
    logic                    tmr_done;
    logic [`PSQ_MS_W-1:0]    on_target;
    logic [`PSQ_MS_W-1:0]    off_target;
    logic [`PSQ_MS_W-1:0]    target;
    logic                    pb_fall;

    // button and kill pins pass two flops before any logic
    psq_sync #(
        .WIDTH   (2),
        .RST_VAL (`PSQ_PINS_RST)
    ) u_sync_pins (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({push_button_n, kill_request_n}),
        .dout  ({pb_s, kill_s})
    );

    // extension straps are pins as well
    psq_sync #(
        .WIDTH   (2 * `PSQ_EXT_W),
        .RST_VAL (`PSQ_EXT_RST)
    ) u_sync_ext (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({on_time_extend, off_time_extend}),
        .dout  ({on_ext, off_ext})
    );

    // common millisecond time base, restarted with each timer
    psq_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .clr   (tmr_restart),
        .tick  (tick)
    );

    // debounce lengths with the configured extensions
    assign on_target  = `PSQ_DB_MS + {{`PSQ_EXT_PAD{1'b0}}, on_ext};
    assign off_target = `PSQ_DB_MS + {{`PSQ_EXT_PAD{1'b0}}, off_ext};
    assign pb_fall    = st.pb_prev && !pb_s;

    // length of the timer running in the present phase
    always_comb begin
        case (st.phase)
            PSQ_ON_DB:   target = on_target;
            PSQ_BLANK:   target = `PSQ_BLANK_MS;
            PSQ_REL_ON:  target = `PSQ_DB_MS;
            PSQ_OFF_DB:  target = off_target;
            PSQ_PDOWN:   target = `PSQ_PDOWN_MS;
            PSQ_LOCKOUT: target = `PSQ_LOCK_MS;
            PSQ_OFF_REL: target = `PSQ_DB_MS;
            default:     target = `PSQ_DB_MS;
        endcase
        tmr_done = (st.ms_cnt >= target);
    end

    // sequencer core: kill filter, phases and timer
    always_comb begin
        next_st         = st;
        tmr_restart     = 1'b0;
        next_st.pb_prev = pb_s;

        // kill must stay low a full filter period to count
        if (kill_s) begin
            next_st.kill_cnt = '0;
            next_st.kill_low = 1'b0;
        end else if (st.kill_cnt == KILL_LAST) begin
            next_st.kill_low = 1'b1;
        end else begin
            next_st.kill_cnt = st.kill_cnt + `PSQ_KILL_W'(1);
        end

        case (st.phase)
            PSQ_IDLE: begin
                next_st.en_on = 1'b0;
                next_st.irq_n = 1'b1;
                // a new power-on starts on a falling edge only
                if (pb_fall) begin
                    next_st.phase = PSQ_ON_DB;
                    tmr_restart   = 1'b1;
                end
            end
            PSQ_ON_DB: begin
                if (pb_s) begin
                    next_st.phase = PSQ_IDLE;
                    tmr_restart   = 1'b1;
                end else if (tmr_done) begin
                    next_st.en_on = 1'b1;
                    next_st.phase = PSQ_BLANK;
                    tmr_restart   = 1'b1;
                end
            end
            PSQ_BLANK: begin
                // button and kill are not looked at until the end
                if (tmr_done) begin
                    tmr_restart = 1'b1;
                    if (st.kill_low) begin
                        next_st.en_on = 1'b0;
                        next_st.phase = PSQ_LOCKOUT;
                    end else begin
                        next_st.phase = PSQ_REL_ON;
                    end
                end
            end
            PSQ_REL_ON: begin
                if (st.kill_low) begin
                    next_st.en_on = 1'b0;
                    next_st.phase = PSQ_LOCKOUT;
                    tmr_restart   = 1'b1;
                end else if (!pb_s) begin
                    tmr_restart = 1'b1;
                end else if (tmr_done) begin
                    next_st.phase = PSQ_RUN;
                    tmr_restart   = 1'b1;
                end
            end
            PSQ_RUN: begin
                if (st.kill_low) begin
                    next_st.en_on = 1'b0;
                    next_st.phase = PSQ_LOCKOUT;
                    tmr_restart   = 1'b1;
                end else if (pb_fall) begin
                    next_st.phase = PSQ_OFF_DB;
                    tmr_restart   = 1'b1;
                end
            end
            PSQ_OFF_DB: begin
                if (st.kill_low) begin
                    next_st.en_on = 1'b0;
                    next_st.phase = PSQ_LOCKOUT;
                    tmr_restart   = 1'b1;
                end else if (pb_s) begin
                    next_st.phase = PSQ_RUN;
                    tmr_restart   = 1'b1;
                end else if (tmr_done) begin
                    next_st.irq_n = 1'b0;
                    next_st.phase = PSQ_PDOWN;
                    tmr_restart   = 1'b1;
                end
            end
            PSQ_PDOWN: begin
                // a tied interrupt shows up here after the filter only
                if (st.kill_low) begin
                    next_st.en_on = 1'b0;
                    next_st.phase = PSQ_LOCKOUT;
                    tmr_restart   = 1'b1;
                end else if (tmr_done) begin
                    next_st.en_on = 1'b0;
                    next_st.phase = PSQ_OFF_REL;
                    tmr_restart   = 1'b1;
                end
            end
            PSQ_LOCKOUT: begin
                // lets the supply decay before a restart is possible
                if (tmr_done) begin
                    next_st.phase = PSQ_OFF_REL;
                    tmr_restart   = 1'b1;
                end
            end
            PSQ_OFF_REL: begin
                if (!pb_s) begin
                    tmr_restart = 1'b1;
                end else if (tmr_done) begin
                    next_st.phase = PSQ_IDLE;
                    next_st.irq_n = 1'b1;
                    tmr_restart   = 1'b1;
                end
            end
            default: begin
                next_st.phase = PSQ_IDLE;
                next_st.en_on = 1'b0;
                next_st.irq_n = 1'b1;
                tmr_restart   = 1'b1;
            end
        endcase

        // timer restarts together with the time base
        if (tmr_restart) begin
            next_st.ms_cnt = '0;
        end else if (tick && !tmr_done) begin
            next_st.ms_cnt = st.ms_cnt + `PSQ_MS_W'(1);
        end

        // pin polarity is the only difference between variants
        next_st.power_enable = next_st.en_on ^ EN_ACTIVE_LOW;

        // synchronous reset: converter off, interrupt idle
        if (!rst_b) begin
            next_st              = '0;
            next_st.phase        = PSQ_IDLE;
            next_st.pb_prev      = 1'b1;
            next_st.irq_n        = 1'b1;
            next_st.en_on        = 1'b0;
            next_st.power_enable = EN_ACTIVE_LOW;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // outputs straight from the state flops
    assign power_enable   = st.power_enable;
    assign shutdown_irq_n = st.irq_n;

    // reset leaves power off and interrupt released
    AST_RESET_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> (!st.en_on && st.irq_n && power_enable == EN_ACTIVE_LOW))
        else $error("enable or interrupt active after reset");

    // enable rises only out of a completed on debounce
    AST_ON_AFTER_DB: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(st.en_on) |-> ($past(st.phase) == PSQ_ON_DB && !$past(pb_s)
                             && $past(st.ms_cnt) >= $past(on_target)))
        else $error("enable asserted without full on debounce");

    // button high during the on debounce abandons it
    AST_DB_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
        (st.phase == PSQ_ON_DB && pb_s) |=> (st.phase == PSQ_IDLE && st.ms_cnt == '0))
        else $error("on debounce survived a button release");

    // nothing leaves the blanking window early
    AST_BLANK_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (st.phase == PSQ_BLANK && !tmr_done) |=> (st.phase == PSQ_BLANK && st.en_on))
        else $error("blanking window left early");

    // kill still low at blank end drops power
    AST_ABORT: assert property (@(posedge clk) disable iff (!rst_b)
        (st.phase == PSQ_BLANK && tmr_done && st.kill_low)
        |=> (!st.en_on ##1 power_enable == EN_ACTIVE_LOW))
        else $error("power-on not aborted with kill low");

    // validated off press pulls the interrupt low
    AST_OFF_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        (st.phase == PSQ_OFF_DB && tmr_done && !pb_s && !st.kill_low)
        |=> (!shutdown_irq_n && st.phase == PSQ_PDOWN && st.en_on))
        else $error("interrupt not raised after off debounce");

    // power-down window timeout releases the enable
    AST_PDOWN_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_b)
        (st.phase == PSQ_PDOWN && tmr_done && !st.kill_low)
        |=> (!st.en_on && st.phase == PSQ_OFF_REL))
        else $error("enable kept after power-down window");

    // recognised kill after blanking acts on the next edge
    AST_KILL_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
        (st.kill_low && (st.phase == PSQ_RUN || st.phase == PSQ_REL_ON
                         || st.phase == PSQ_OFF_DB || st.phase == PSQ_PDOWN))
        |=> (!st.en_on && st.phase == PSQ_LOCKOUT))
        else $error("kill did not release the enable");

    // lockout holds until its timer ends
    AST_LOCKOUT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (st.phase == PSQ_LOCKOUT && !tmr_done) |=> (st.phase == PSQ_LOCKOUT && !st.en_on))
        else $error("lockout left early");

    // output pin active exactly in the powered phases, either polarity
    AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_b)
        power_enable == ((st.phase inside {PSQ_BLANK, PSQ_REL_ON, PSQ_RUN, PSQ_OFF_DB,
                                           PSQ_PDOWN}) ^ EN_ACTIVE_LOW))
        else $error("enable pin polarity wrong");

    // any high on kill clears recognition
    AST_KILL_GLITCH: assert property (@(posedge clk) disable iff (!rst_b)
        kill_s |=> (!st.kill_low && st.kill_cnt == '0))
        else $error("short kill pulse recognised");

    // kill recognised once the filter count completes
    AST_KILL_LATENCY: assert property (@(posedge clk) disable iff (!rst_b)
        (!kill_s && st.kill_cnt == KILL_LAST) |=> st.kill_low)
        else $error("kill recognised too late");

    // interrupt is released whenever the block idles
    AST_IRQ_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
        (st.phase == PSQ_IDLE) |-> (shutdown_irq_n && !st.en_on))
        else $error("interrupt low or enable on in idle");

endmodule // psq_sequencer

/* rtl/psq_sync.sv */
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are quasi-static or slow against clk
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps

module psq_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // asynchronous pins and synchronised copy
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } psq_sync_st_t;

    psq_sync_st_t st;
    psq_sync_st_t next_st;

    // shift the pins through both stages
    always_comb begin
        next_st.s1 = din;
        next_st.s2 = st.s1;
        if (!rst_b) begin
            next_st.s1 = RST_VAL;
            next_st.s2 = RST_VAL;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign dout = st.s2;

endmodule // psq_sync

/* rtl/psq_tick.sv */
// Purpose: millisecond time base for the sequencer timers
// Assumes: TICK_CYCLES fits the counter width
// Notes:   clr restarts the period so a fresh timer sees whole ms
`timescale 1ns/1ps
`include "psq_regs.svh"

module psq_tick #(
    parameter int TICK_CYCLES = `PSQ_TICK_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // restart and tick pulse
    input  wire logic clr,
    output logic      tick
);

    localparam logic [`PSQ_TICK_W-1:0] LAST = `PSQ_TICK_W'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [`PSQ_TICK_W-1:0] cnt;
        logic                   tick;
    } psq_tick_st_t;

    psq_tick_st_t st;
    psq_tick_st_t next_st;

    // free counter, one pulse per period
    always_comb begin
        next_st.tick = 1'b0;
        next_st.cnt  = st.cnt + `PSQ_TICK_W'(1);
        if (st.cnt == LAST) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end
        if (clr || !rst_b) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign tick = st.tick;

endmodule // psq_tick

/* tb/psq_partner.sv */
// Purpose: pushbutton and supervising processor beside the sequencer
// Assumes: pins change 1 ns after a rising clock edge
// Notes:   kill may be tied to the interrupt, as a board strap would do
`timescale 1ns/1ps

module psq_partner (
    // clock
    input  wire logic clk,
    // warning from the sequencer
    input  wire logic shutdown_irq_n,
    // pins towards the sequencer
    output logic      push_button_n,
    output logic      kill_request_n
);
    logic pb_lvl;
    logic kill_lvl;
    logic tie;

    // unpowered processor holds kill low until it wakes
    initial begin
        pb_lvl   = 1'b1;
        kill_lvl = 1'b0;
        tie      = 1'b0;
    end

    // button idles high through its pull-up
    assign push_button_n  = pb_lvl;
    assign kill_request_n = tie ? shutdown_irq_n : kill_lvl;

    // each change lands just after an edge, never on it
    task automatic set_pb(input logic lvl);
        @(posedge clk);
        #1 pb_lvl = lvl;
    endtask

    task automatic set_kill(input logic lvl);
        @(posedge clk);
        #1 kill_lvl = lvl;
    endtask

    task automatic set_tie(input logic on);
        @(posedge clk);
        #1 tie = on;
    endtask
endmodule // psq_partner

/* tb/psq_sequencer_tb_top.sv */
// Purpose: self-checking bench of the pushbutton power sequencer
// Assumes: ms timers shortened to 10 cycles per tick
// Notes:   drivers queue expected output changes; a monitor checks them
`timescale 1ns/1ps
`include "psq_regs.svh"

module psq_sequencer_tb_top;
    import psq_pkg::*;
    localparam int MS = 10;
    typedef struct {logic en; logic irq; int lo; int hi;} psq_note_t;

    logic                  clk;
    logic                  rst_b;
    logic                  push_button_n;
    logic                  kill_request_n;
    logic [`PSQ_EXT_W-1:0] on_time_extend;
    logic [`PSQ_EXT_W-1:0] off_time_extend;
    logic                  power_enable;
    logic                  power_enable_low;
    logic                  shutdown_irq_n;
    logic [1:0]            prev;
    int                    cyc;
    int                    last_evt;
    int                    mismatches;
    int                    n_compared;
    int                    k;
    int                    seed;
    psq_note_t             notes[$];

    psq_sequencer #(.TICK_CYCLES(MS), .EN_ACTIVE_LOW(1'b0)) psq_sequencer_inst (
        .clk(clk), .rst_b(rst_b), .push_button_n(push_button_n),
        .kill_request_n(kill_request_n), .on_time_extend(on_time_extend),
        .off_time_extend(off_time_extend), .power_enable(power_enable),
        .shutdown_irq_n(shutdown_irq_n));
    // second copy only to compare enable polarity
    psq_sequencer #(.TICK_CYCLES(MS), .EN_ACTIVE_LOW(1'b1)) psq_sequencer_low_inst (
        .clk(clk), .rst_b(rst_b), .push_button_n(push_button_n),
        .kill_request_n(kill_request_n), .on_time_extend(on_time_extend),
        .off_time_extend(off_time_extend), .power_enable(power_enable_low),
        .shutdown_irq_n());
    psq_partner psq_partner_inst (
        .clk(clk), .shutdown_irq_n(shutdown_irq_n),
        .push_button_n(push_button_n), .kill_request_n(kill_request_n));

    // 50 MHz clock
    always #10 clk = ~clk;

    always @(posedge clk) cyc <= cyc + 1;

    task automatic end_sim();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic compare_evt(input psq_note_t n);
        n_compared++;
        if (power_enable !== n.en || shutdown_irq_n !== n.irq || cyc < n.lo || cyc > n.hi) begin
            mismatches++;
            $display("mismatch at %0t: got %b%b at cycle %0d, want %b%b in %0d..%0d", $time,
                     power_enable, shutdown_irq_n, cyc, n.en, n.irq, n.lo, n.hi);
        end
    endtask

    task automatic compare_pol();
        n_compared++;
        if (power_enable_low !== ~power_enable) begin
            mismatches++;
            $display("mismatch at %0t: low-true enable not inverse", $time);
        end
    endtask

    // monitor at falling edge, where flop outputs have settled
    always @(negedge clk) begin
        if (rst_b === 1'b1 && {power_enable, shutdown_irq_n} !== prev) begin
            compare_pol();
            if (notes.size() == 0) begin
                mismatches++;
                $display("mismatch at %0t: unexpected output change", $time);
            end else begin
                compare_evt(notes.pop_front());
            end
            last_evt = cyc;
        end
        prev = {power_enable, shutdown_irq_n};
    end

    task automatic ev(input logic en, input logic irq, input int lo, input int hi);
        psq_note_t n;
        n.en  = en;
        n.irq = irq;
        n.lo  = lo;
        n.hi  = hi;
        notes.push_back(n);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bounded wait until every queued change has shown
    task automatic wait_evts(input int limit);
        for (int i = 0; i < limit && notes.size() != 0; i++) @(posedge clk);
        if (notes.size() != 0) begin
            mismatches++;
            $display("mismatch at %0t: expected change never came", $time);
            end_sim();
        end
    endtask

    // press and hold until enable; leaves the button pressed
    task automatic power_on();
        psq_partner_inst.set_pb(1'b0);
        on_time_extend = 8'($random(seed)); // new strap value for each press
        k = cyc;
        ev(1'b1, 1'b1, k + (32 + int'(on_time_extend)) * MS,
           k + (32 + int'(on_time_extend)) * MS + 20);
        wait_evts(4000);
    endtask

    // press in run until the warning shows
    task automatic off_press();
        psq_partner_inst.set_pb(1'b0);
        off_time_extend = 8'($random(seed)); // new strap value for each press
        k = cyc;
        ev(1'b1, 1'b0, k + (32 + int'(off_time_extend)) * MS,
           k + (32 + int'(off_time_extend)) * MS + 20);
        wait_evts(4000);
        psq_partner_inst.set_pb(1'b1);
    endtask

    initial begin
        seed            = 32'h8186;
        clk             = 1'b0;
        rst_b           = 1'b0;
        cyc             = 0;
        last_evt        = 0;
        mismatches      = 0;
        n_compared      = 0;
        prev            = 2'h0;
        on_time_extend  = 8'($random(seed));
        off_time_extend = 8'($random(seed));
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        @(negedge clk);
        compare_evt('{1'b0, 1'b1, cyc, cyc});
        cycles(10);
        // short press, then release: debounce must start over
        psq_partner_inst.set_pb(1'b0);
        cycles(200);
        psq_partner_inst.set_pb(1'b1);
        cycles(20);
        power_on();
        // kill left low through blanking aborts; button ignored meanwhile
        ev(1'b0, 1'b1, last_evt + 512 * MS, last_evt + 512 * MS + 10);
        psq_partner_inst.set_pb(1'b1);
        cycles(100);
        psq_partner_inst.set_pb(1'b0);
        cycles(400);
        psq_partner_inst.set_pb(1'b1);
        wait_evts(6000);
        cycles(256 * MS + 32 * MS + 40);
        // normal start, glitch on kill, then a real kill
        power_on();
        psq_partner_inst.set_pb(1'b1);
        cycles(300 * MS);
        psq_partner_inst.set_kill(1'b1);
        cycles(512 * MS);
        psq_partner_inst.set_kill(1'b0);
        cycles(100 + int'(10'($random(seed))));
        psq_partner_inst.set_kill(1'b1);
        cycles(100);
        psq_partner_inst.set_kill(1'b0);
        k = cyc;
        ev(1'b0, 1'b1, k + 1490, k + 1500);
        wait_evts(2000);
        // press in lockout is ignored
        psq_partner_inst.set_pb(1'b0);
        cycles(400);
        psq_partner_inst.set_pb(1'b1);
        psq_partner_inst.set_kill(1'b1);
        cycles(256 * MS + 32 * MS + 40);
        // off press with no answer from the processor
        power_on();
        psq_partner_inst.set_pb(1'b1);
        cycles(512 * MS + 32 * MS + 40);
        off_press();
        ev(1'b0, 1'b0, last_evt + 1024 * MS, last_evt + 1024 * MS + 10);
        wait_evts(11000);
        ev(1'b0, 1'b1, last_evt + 32 * MS, last_evt + 32 * MS + 10);
        wait_evts(1000);
        // interrupt strapped to kill releases enable after the filter
        power_on();
        psq_partner_inst.set_pb(1'b1);
        cycles(512 * MS + 32 * MS + 40);
        psq_partner_inst.set_tie(1'b1);
        off_press();
        ev(1'b0, 1'b0, last_evt + 1490, last_evt + 1500);
        wait_evts(2000);
        ev(1'b0, 1'b1, last_evt + 288 * MS, last_evt + 288 * MS + 20);
        wait_evts(4000);
        cycles(100);
        end_sim();
    end
endmodule // psq_sequencer_tb_top
